// File: design/sbpa_arbiter.sv
/*
 * System bus priority arbiter with its APB control register.
 * Assumes requests, locks and APB signals come from logic on pclk; a master
 * holds its request for as long as it wants the bus.
 */
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps

// Behaviour
// - Control bit 31: 0 round-robin, 1 fixed
// - Writable 2-bit group ranks in bits 7:0
// - Read-only ranks in effect in bits 15:8
// - Programmed ranks used only in fixed mode
// - Register resets to 0x80001B1B
// - Bridge DMA channels request the bus too
// - Round-robin: served group drops to last rank
// - CPU wrapper always lowest priority
// - Refresh first; write buffer below groups
// - Locked DMA operation keeps the bus
module sbpa_arbiter (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [sbpa_pkg::NUM_M-1:0]  bus_req,
	input  wire logic [sbpa_pkg::NUM_M-1:0]  bus_lock,
	output logic      [sbpa_pkg::NUM_M-1:0]  bus_grant
);

	typedef struct packed {
		sbpa_pkg::sbpa_state_type           st;
		logic [sbpa_pkg::M_W-1:0]           owner;
		logic                               fix;
		logic [sbpa_pkg::RANKS_W-1:0]       rank;
		logic [sbpa_pkg::RANKS_W-1:0]       rr_rank;
		logic [31:0]                        rdata;
	} sbpa_regs_type;

	localparam sbpa_regs_type REGS_RESET = '{
		st:      sbpa_pkg::SBPA_IDLE,
		owner:   '0,
		fix:     sbpa_pkg::FIX_RESET,
		rank:    sbpa_pkg::RANKS_RESET,
		rr_rank: sbpa_pkg::RANKS_RESET,
		rdata:   '0
	};

	sbpa_regs_type                   r_ff;
	sbpa_regs_type                   nxt_r;
	logic [sbpa_pkg::RANKS_W-1:0]    eff_rank;
	logic [sbpa_pkg::NUM_GRP-1:0]    grp_req;
	logic [sbpa_pkg::GRP_W-1:0]      pick_sel;
	logic                            pick_valid;
	logic                            hit;
	logic                            wr_acc;
	logic                            rd_setup;

	// Ranks in force: programmed in fixed mode, rotating otherwise
	assign eff_rank = r_ff.fix ? r_ff.rank : r_ff.rr_rank;

	// Group requests; both bridge channels compete as the bridge group
	assign grp_req[sbpa_pkg::GRP_DISP] = bus_req[sbpa_pkg::M_DISP];
	assign grp_req[sbpa_pkg::GRP_GDMA] = bus_req[sbpa_pkg::M_GDMA0] | bus_req[sbpa_pkg::M_GDMA1];
	assign grp_req[sbpa_pkg::GRP_BRIDGE_DMA_RANK] = bus_req[sbpa_pkg::M_BDMA0] | bus_req[sbpa_pkg::M_BDMA1];
	assign grp_req[sbpa_pkg::GRP_EXT]  = bus_req[sbpa_pkg::M_EXT];

	sbpa_pick u_pick (
		.grp_req (grp_req),
		.ranks   (eff_rank),
		.sel     (pick_sel),
		.valid   (pick_valid)
	);

	// Zero wait-state slave; unmapped addresses answer with an error
	assign hit      = (paddr == sbpa_pkg::CTRL_OFFSET);
	assign wr_acc   = psel & penable & pwrite & hit;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready   = psel & penable;
	assign pslverr  = psel & penable & ~hit;
	assign prdata   = r_ff.rdata;

	// One grant line per master, decoded from the registered owner
	genvar gi;
	generate
		for (gi = 0; gi < sbpa_pkg::NUM_M; gi++) begin : g_grant
			assign bus_grant[gi] = (r_ff.st == sbpa_pkg::SBPA_OWNED) &&
				(r_ff.owner == sbpa_pkg::M_W'(gi));
		end
	endgenerate

	// Next-state logic: arbitration, rotation and register access
	always_comb begin
		logic [sbpa_pkg::RANK_W-1:0] old_rank;
		logic [sbpa_pkg::RANK_W-1:0] cur;
		nxt_r    = r_ff;
		old_rank = '0;
		cur      = '0;
		unique case (r_ff.st)
			sbpa_pkg::SBPA_IDLE: begin
				// Fixed order outside the groups: refresh, groups, buffer, CPU
				if (bus_req[sbpa_pkg::M_REFRESH]) begin
					nxt_r.st    = sbpa_pkg::SBPA_OWNED;
					nxt_r.owner = sbpa_pkg::M_W'(sbpa_pkg::M_REFRESH);
				end else if (pick_valid) begin
					nxt_r.st = sbpa_pkg::SBPA_OWNED;
					unique case (pick_sel)
						sbpa_pkg::GRP_DISP: nxt_r.owner = sbpa_pkg::M_W'(sbpa_pkg::M_DISP);
						sbpa_pkg::GRP_GDMA: nxt_r.owner = bus_req[sbpa_pkg::M_GDMA0] ?
							sbpa_pkg::M_W'(sbpa_pkg::M_GDMA0) : sbpa_pkg::M_W'(sbpa_pkg::M_GDMA1);
						sbpa_pkg::GRP_BRIDGE_DMA_RANK: nxt_r.owner = bus_req[sbpa_pkg::M_BDMA0] ?
							sbpa_pkg::M_W'(sbpa_pkg::M_BDMA0) : sbpa_pkg::M_W'(sbpa_pkg::M_BDMA1);
						sbpa_pkg::GRP_EXT:  nxt_r.owner = sbpa_pkg::M_W'(sbpa_pkg::M_EXT);
					endcase
					// Served group goes last, the ones behind it move up
					if (!r_ff.fix) begin
						old_rank = r_ff.rr_rank[sbpa_pkg::RANK_W*(sbpa_pkg::NUM_GRP-1-pick_sel)
							+: sbpa_pkg::RANK_W];
						for (int g = 0; g < sbpa_pkg::NUM_GRP; g++) begin
							cur = r_ff.rr_rank[sbpa_pkg::RANK_W*(sbpa_pkg::NUM_GRP-1-g)
								+: sbpa_pkg::RANK_W];
							if (sbpa_pkg::GRP_W'(g) == pick_sel)
								cur = sbpa_pkg::RANK_LAST;
							else if (cur > old_rank)
								cur = cur - 2'h1;
							nxt_r.rr_rank[sbpa_pkg::RANK_W*(sbpa_pkg::NUM_GRP-1-g)
								+: sbpa_pkg::RANK_W] = cur;
						end
					end
				end else if (bus_req[sbpa_pkg::M_WBUF]) begin
					nxt_r.st    = sbpa_pkg::SBPA_OWNED;
					nxt_r.owner = sbpa_pkg::M_W'(sbpa_pkg::M_WBUF);
				end else if (bus_req[sbpa_pkg::M_CPU]) begin
					nxt_r.st    = sbpa_pkg::SBPA_OWNED;
					nxt_r.owner = sbpa_pkg::M_W'(sbpa_pkg::M_CPU);
				end
			end
			sbpa_pkg::SBPA_OWNED: begin
				// Release needs request and lock both gone; one idle cycle
				// between owners keeps grants from ever overlapping
				if (!bus_req[r_ff.owner] && !bus_lock[r_ff.owner])
					nxt_r.st = sbpa_pkg::SBPA_IDLE;
			end
		endcase
		// Read data captured in the setup phase, shown in the access phase
		if (rd_setup) begin
			nxt_r.rdata = '0;
			if (hit) begin
				nxt_r.rdata[sbpa_pkg::FIX_BIT] = r_ff.fix;
				nxt_r.rdata[sbpa_pkg::STATUS_LSB +: sbpa_pkg::RANKS_W] = eff_rank;
				nxt_r.rdata[sbpa_pkg::RANK_LSB +: sbpa_pkg::RANKS_W]   = r_ff.rank;
			end
		end
		// A write leaves the rotating ranks alone; entering round-robin starts from the new ranks
		if (wr_acc) begin
			nxt_r.fix  = pwdata[sbpa_pkg::FIX_BIT];
			nxt_r.rank = pwdata[sbpa_pkg::RANK_LSB +: sbpa_pkg::RANKS_W];
			if (r_ff.fix && !pwdata[sbpa_pkg::FIX_BIT])
				nxt_r.rr_rank = pwdata[sbpa_pkg::RANK_LSB +: sbpa_pkg::RANKS_W];
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			r_ff <= REGS_RESET;
		else
			r_ff <= nxt_r;
	end

	// Checks
	AST_ONE_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot0(bus_grant)) else $error("more than one grant");

	AST_REFRESH_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		(r_ff.st == sbpa_pkg::SBPA_IDLE && bus_req[sbpa_pkg::M_REFRESH])
		|=> bus_grant[sbpa_pkg::M_REFRESH]) else $error("refresh not granted first");

	AST_CPU_LAST: assert property (@(posedge pclk) disable iff (!presetn)
		(r_ff.st == sbpa_pkg::SBPA_IDLE && bus_req[sbpa_pkg::M_CPU] &&
		 (bus_req[sbpa_pkg::M_CPU-1:0] != '0)) |=> !bus_grant[sbpa_pkg::M_CPU])
		else $error("cpu granted over another master");

	AST_LOCK_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(r_ff.st == sbpa_pkg::SBPA_OWNED && bus_lock[r_ff.owner])
		|=> $stable(bus_grant) && (bus_grant != '0)) else $error("locked owner lost bus");

	AST_BRIDGE_SERVED: assert property (@(posedge pclk) disable iff (!presetn)
		(r_ff.st == sbpa_pkg::SBPA_IDLE && bus_req == (1 << sbpa_pkg::M_BDMA1))
		|=> bus_grant[sbpa_pkg::M_BDMA1]) else $error("bridge channel not granted");

	// Only the external group asks, so its field sits in the low bits and must end last;
	// a write in the same cycle leaves rotation alone, yet it is left out too
	AST_RR_ROTATE: assert property (@(posedge pclk) disable iff (!presetn)
		(r_ff.st == sbpa_pkg::SBPA_IDLE && !r_ff.fix && !wr_acc &&
		 !bus_req[sbpa_pkg::M_REFRESH] && grp_req[sbpa_pkg::GRP_EXT] && grp_req == 4'h8)
		|=> r_ff.rr_rank[sbpa_pkg::RANK_W-1:0] == sbpa_pkg::RANK_LAST)
		else $error("served group not moved last");

	AST_FIX_STATIC: assert property (@(posedge pclk) disable iff (!presetn)
		(r_ff.fix && !wr_acc) |=> $stable(r_ff.rank) && (eff_rank == r_ff.rank))
		else $error("fixed ranks changed without write");

	// Write data is gone after the access cycle, so it is looked at one cycle back
	AST_RANK_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc |=> r_ff.rank == $past(pwdata[sbpa_pkg::RANK_LSB +: sbpa_pkg::RANKS_W]) &&
		r_ff.fix == $past(pwdata[sbpa_pkg::FIX_BIT]))
		else $error("rank write not stored");

	AST_STATUS_READ: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && hit) |=> prdata[sbpa_pkg::STATUS_LSB +: sbpa_pkg::RANKS_W] == $past(eff_rank) &&
		prdata[30:16] == '0)
		else $error("status fields wrong");

	AST_MODE_PICK: assert property (@(posedge pclk) disable iff (!presetn)
		(r_ff.st == sbpa_pkg::SBPA_IDLE && r_ff.fix && r_ff.rank == sbpa_pkg::RANKS_RESET &&
		 bus_req[sbpa_pkg::M_DISP] && !bus_req[sbpa_pkg::M_REFRESH])
		|=> bus_grant[sbpa_pkg::M_DISP]) else $error("fixed order not kept");

endmodule

// File: design/sbpa_pick.sv
/*
 * Rank picker: returns the requesting group with the best rank.
 * Assumes ranks packed with group 0 in the top field; equal ranks are
 * broken in favour of the lower group index.
 */
`timescale 1ns/1ps

module sbpa_pick (
	input  wire logic [sbpa_pkg::NUM_GRP-1:0] grp_req,
	input  wire logic [sbpa_pkg::RANKS_W-1:0] ranks,
	output logic      [sbpa_pkg::GRP_W-1:0]   sel,
	output logic                              valid
);

	// Scan worst level first so the best level and lowest group win last
	always_comb begin
		valid = 1'b0;
		sel   = '0;
		for (int lvl = sbpa_pkg::NUM_GRP - 1; lvl >= 0; lvl--) begin
			for (int g = sbpa_pkg::NUM_GRP - 1; g >= 0; g--) begin
				if (grp_req[g] && ranks[sbpa_pkg::RANK_W*(sbpa_pkg::NUM_GRP-1-g) +:
						sbpa_pkg::RANK_W] == sbpa_pkg::RANK_W'(lvl)) begin
					valid = 1'b1;
					sel   = sbpa_pkg::GRP_W'(g);
				end
			end
		end
	end

endmodule

// File: design/sbpa_pkg.sv
/*
 * Shared constants of the system bus priority arbiter: master indices,
 * requester groups, control register layout, offset and reset value.
 * Assumes nothing of its surroundings.
 */
package sbpa_pkg;

	// Bus masters, one request line each
	localparam int NUM_M    = 9;
	localparam int M_W      = 4;
	localparam int M_REFRESH = 0;
	localparam int M_DISP   = 1;
	localparam int M_GDMA0  = 2;
	localparam int M_GDMA1  = 3;
	localparam int M_BDMA0  = 4;
	localparam int M_BDMA1  = 5;
	localparam int M_EXT    = 6;
	localparam int M_WBUF   = 7;
	localparam int M_CPU    = 8;

	// Programmable requester groups
	localparam int NUM_GRP  = 4;
	localparam int GRP_W    = 2;
	localparam int RANK_W   = 2;
	localparam int RANKS_W  = NUM_GRP * RANK_W;
	localparam logic [GRP_W-1:0] GRP_DISP = 2'h0;
	localparam logic [GRP_W-1:0] GRP_GDMA = 2'h1;
	localparam logic [GRP_W-1:0] GRP_BRIDGE_DMA_RANK = 2'h2;
	localparam logic [GRP_W-1:0] GRP_EXT  = 2'h3;
	localparam logic [RANK_W-1:0] RANK_LAST = 2'h3;

	// Control register
	localparam logic [31:0] CTRL_OFFSET = 32'h01C40000;
	localparam logic [31:0] CTRL_RESET  = 32'h80001B1B;
	localparam int FIX_BIT     = 31;
	localparam int STATUS_LSB  = 8;
	localparam int RANK_LSB    = 0;
	localparam logic [RANKS_W-1:0] RANKS_RESET = CTRL_RESET[RANK_LSB +: RANKS_W];
	localparam logic FIX_RESET = CTRL_RESET[FIX_BIT];

	// Arbiter state
	typedef enum logic {
		SBPA_IDLE,
		SBPA_OWNED
	} sbpa_state_type;

endpackage

// File: sim/sbpa_masters.sv
/* Bus requester model: the masters that ask the arbiter for the bus.
 * Assumes kick pulses and grants are synchronous to pclk. */
`timescale 1ns/1ps
module sbpa_masters (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [8:0] kick,
	input  wire logic [8:0] lock_en,
	input  wire logic [8:0] bus_grant,
	output logic      [8:0] bus_req,
	output logic      [8:0] bus_lock
);
	logic [2:0] cnt_ff [9];

	// Request drops three cycles into ownership; a locked op outlives it by two more
	always_ff @(posedge pclk or negedge presetn) begin
		for (int i = 0; i < 9; i++) begin
			if (!presetn) begin
				bus_req[i] <= 1'b0;
				bus_lock[i] <= 1'b0;
				cnt_ff[i] <= 3'h0;
			end else begin
				if (kick[i]) begin
					bus_req[i] <= 1'b1;
				end else if (bus_grant[i] && cnt_ff[i] == 3'h2) begin
					bus_req[i] <= 1'b0;
				end
				cnt_ff[i] <= bus_grant[i] ? cnt_ff[i] + 3'h1 : 3'h0;
				bus_lock[i] <= lock_en[i] && bus_grant[i] && cnt_ff[i] < 3'h4;
			end
		end
	end
endmodule

// File: sim/system_bus_priority_arbiter_tb_top.sv
/* Self-checking bench of the bus priority arbiter: APB register access and
 * grant order in fixed and rotating modes. Assumes the requester model. */
`timescale 1ns/1ps
module system_bus_priority_arbiter_tb_top;
	localparam logic [31:0] A = sbpa_pkg::CTRL_OFFSET;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, err;
	logic [8:0]  kick = 9'h0, lock_en = 9'h004, bus_req, bus_lock, bus_grant, prev_g = 9'h0, msk;
	logic [7:0]  rk, rr;
	int          bad_count = 0, n_checks = 0, seed = 73, lock_bad = 0, lock_held = 0, multi = 0;
	int          exp_q[$], got_q[$];
	int          lo[4] = '{1, 2, 4, 6}; // First channel of each group

	always #50 pclk = ~pclk;

	sbpa_arbiter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_req(bus_req), .bus_lock(bus_lock), .bus_grant(bus_grant));
	sbpa_masters req_u (.pclk(pclk), .presetn(presetn), .kick(kick), .lock_en(lock_en),
		.bus_grant(bus_grant), .bus_req(bus_req), .bus_lock(bus_lock));

	// Log each new owner; a lock must keep its grant, and grants never overlap
	always @(posedge pclk) begin
		prev_g <= bus_grant;
		for (int i = 0; i < 9; i++) if (bus_grant[i] === 1'b1 && !prev_g[i]) got_q.push_back(i);
		if ($countones(bus_grant) > 1) multi++;
		if ((bus_lock & ~bus_grant) != 9'h0) lock_bad++;
		if ((bus_lock & ~bus_req & bus_grant) != 9'h0) lock_held++;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wrap_up;
		if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// One APB transfer; request held until pready is seen, then an idle cycle
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No fixed wait count: only the watchdog ends a stuck transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Best requesting group: lowest rank, ties to the lower group
	function int best(input logic [7:0] r, input logic [3:0] m);
		int b;
		b = -1;
		for (int g = 0; g < 4; g++) if (m[g] && (b < 0 || r[7-2*g -: 2] < r[7-2*b -: 2])) b = g;
		return b;
	endfunction

	// Expected owner order for masters m; ranks rotate after each group service if rot
	task exp_order(input logic [8:0] m, input logic rot, inout logic [7:0] r);
		int g, i;
		logic [1:0] t;
		exp_q.delete();
		if (m[0]) exp_q.push_back(0);
		for (int k = 0; k < 6; k++) begin
			g = best(r, {m[6], m[5] | m[4], m[3] | m[2], m[1]});
			if (g >= 0) begin
				i = m[lo[g]] ? lo[g] : lo[g] + 1;
				exp_q.push_back(i);
				m[i] = 1'b0;
				t = r[7-2*g -: 2];
				for (int h = 0; h < 4; h++) if (rot && r[7-2*h -: 2] > t) r[7-2*h -: 2] -= 2'h1;
				if (rot) r[7-2*g -: 2] = 2'h3;
			end
		end
		for (int k = 7; k < 9; k++) if (m[k]) exp_q.push_back(k);
	endtask

	// Kick masters together, let them all finish, compare owner sequence
	task round(input logic [8:0] m);
		got_q.delete();
		kick <= m;
		@(posedge pclk);
		kick <= 9'h0;
		repeat (3) @(posedge pclk);
		for (int k = 0; k < 300 && (bus_req | bus_grant) != 9'h0; k++) @(posedge pclk);
		chk(32'(bus_req | bus_grant), 32'h0);
		chk(32'(got_q.size()), 32'(exp_q.size()));
		foreach (exp_q[k]) chk(32'(got_q[k]), 32'(exp_q[k]));
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, A, 32'h0);
		chk(q, 32'h80001B1B);
		apb(1'b1, A + 32'h4, 32'hFFFFFFFF);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, A + 32'h4, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, A, 32'h0);
		chk(q, 32'h80001B1B);
		// First pass keeps the reset order as a hand-written corner
		for (int n = 0; n < 3; n++) begin
			rk = (n == 0) ? 8'h1B : 8'($random(seed));
			apb(1'b1, A, {24'h800000, rk});
			apb(1'b0, A, 32'h0);
			chk(q, {16'h8000, rk, rk});
			exp_order(9'h1FF, 1'b0, rk);
			round(9'h1FF);
		end
		rr = 8'h93;
		apb(1'b1, A, 32'h00000093);
		for (int n = 0; n < 5; n++) begin
			msk = 9'($random(seed));
			exp_order(msk, 1'b1, rr);
			round(msk);
			rk = 8'($random(seed));
			apb(1'b1, A, {24'h0, rk});
			apb(1'b0, A, 32'h0);
			chk(q, {16'h0, rr, rk});
		end
		// Lone requesters: bridge channel 1, then the external group
		exp_order(9'h020, 1'b1, rr);
		round(9'h020);
		exp_order(9'h040, 1'b1, rr);
		round(9'h040);
		apb(1'b0, A, 32'h0);
		chk(q, {16'h0, rr, rk});
		chk(32'(lock_bad), 32'h0);
		chk(32'(lock_held > 0), 32'h1);
		chk(32'(multi), 32'h0);
		wrap_up;
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		wrap_up;
	end
endmodule
